// ===== hdl/kbh_pkg.sv
// shared constants for the keyboard/pointer host port
package kbh_pkg;
  // host i/o port addresses
  localparam logic [8:0] PORT_CFG_INDEX = 9'h15C;
  localparam logic [8:0] PORT_CFG_DATA  = 9'h15D;
  localparam logic [8:0] PORT_DATA      = 9'h060;
  localparam logic [8:0] PORT_STATUS    = 9'h064;
  // configuration register indices
  localparam logic [7:0] IDX_LDN       = 8'h07;
  localparam logic [7:0] IDX_ACTIVATE  = 8'h30;
  localparam logic [7:0] IDX_RANGE     = 8'h31;
  localparam logic [7:0] IDX_BASE_HI   = 8'h60;
  localparam logic [7:0] IDX_BASE_LO   = 8'h61;
  localparam logic [7:0] IDX_CBASE_HI  = 8'h62;
  localparam logic [7:0] IDX_CBASE_LO  = 8'h63;
  localparam logic [7:0] IDX_IRQ_SEL   = 8'h70;
  localparam logic [7:0] IDX_IRQ_TYPE  = 8'h71;
  localparam logic [7:0] IDX_DMA_SEL   = 8'h74;
  localparam logic [7:0] IDX_DMA_RPT   = 8'h75;
  localparam logic [7:0] IDX_CFG_DATA  = 8'hF0;
  localparam logic [7:0] LDN_KBD       = 8'h00;
  localparam logic [7:0] LDN_PTR       = 8'h01;
  localparam logic [7:0] ACTIVATE_ON   = 8'h01;
  // configuration reset values, keyboard / pointer
  localparam logic [7:0] RST_ACT_KBD   = 8'h01;
  localparam logic [7:0] RST_ACT_PTR   = 8'h00;
  localparam logic [7:0] RST_RANGE     = 8'h00;
  localparam logic [7:0] RST_BASE_HI   = 8'h02;
  localparam logic [7:0] RST_BASE_LO   = 8'h78;
  localparam logic [7:0] RST_CBASE     = 8'h00;
  localparam logic [7:0] RST_IRQS_KBD  = 8'h01;
  localparam logic [7:0] RST_IRQS_PTR  = 8'h0C;
  localparam logic [7:0] RST_IRQ_TYPE  = 8'h01;
  localparam logic [7:0] RST_DMA       = 8'h04;
  localparam logic [7:0] RST_CFG_DATA  = 8'h00;
  // controller commands
  localparam logic [7:0] CMD_READ_CB   = 8'h20;
  localparam logic [7:0] CMD_WRITE_CB  = 8'h60;
  // command byte layout
  localparam int         CB_CONVERT    = 6;
  localparam int         CB_PTR_OFF    = 5;
  localparam int         CB_KBD_OFF    = 4;
  localparam int         CB_SYS_FLAG   = 2;
  localparam logic [7:0] CB_WRITE_MASK = 8'h77;
  localparam logic [7:0] RST_CMD_BYTE  = 8'h00;
  // status byte layout
  localparam int         ST_CMD_DATA   = 3;
  localparam int         ST_IBF        = 1;
  localparam int         ST_OBF        = 0;
  // legacy code conversion
  localparam logic [7:0] CODE_BREAK    = 8'hF0;
  localparam logic [7:0] CODE_REL_MASK = 8'h80;
  // host controller operations
  typedef enum logic [2:0] {
    OP_ACTIVATE  = 3'b000,
    OP_WR_CMD    = 3'b001,
    OP_WR_DATA   = 3'b010,
    OP_RD_DATA   = 3'b011,
    OP_RD_STATUS = 3'b100
  } kbh_op_t;
  // host controller register offsets
  localparam logic [1:0] HREG_CTRL     = 2'h0;
  localparam logic [1:0] HREG_OPERAND  = 2'h1;
  localparam logic [1:0] HREG_RESULT   = 2'h2;
  localparam logic [1:0] HREG_STATUS   = 2'h3;
endpackage

// ===== hdl/kbh_if.sv
// host i/o bus between cpu side and keyboard/pointer controller
`timescale 1ns/1ns
interface kbh_if;
  logic [8:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       keyboard_interrupt_line;
  logic       pointer_interrupt_line;
  modport dev (
    input  addr, wdata, wr, rd,
    output rdata, keyboard_interrupt_line, pointer_interrupt_line
  );
  modport host (
    output addr, wdata, wr, rd,
    input  rdata, keyboard_interrupt_line, pointer_interrupt_line
  );
endinterface

// ===== hdl/kbh_device.sv
// keyboard/pointer controller: config path, data/status ports, command byte
// What this block does
// - config registers reached through index/data ports
// - host selects logical device via index 07h
// - writing 01h to index 30h activates device
// - data port read returns output buffer byte
// - data port write loads buffer, marks data
// - data bytes go to keyboard unless parameter
// - command port write loads buffer, marks command
// - status bit 3 follows address line two
// - input full set by write, cleared on fetch
// - output full cleared by host data read
// - host checks output full before reading
// - host checks input empty before writing
// - keyboard service on keyboard interrupt line
// - command 20h returns command byte
// - command 60h stores next data byte under mask 77h (bits 7 and 3 cleared)
// - command bit 6 enables code conversion
// - command bit 5 disables pointing device
// - command bit 4 disables keyboard
// - command bit 2 is readable system flag
// - pointer service on separate interrupt line
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ns
module kbh_device (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // host bus
  kbh_if.dev              bus,
  // keyboard receive
  input  wire logic       kbd_valid_i,
  input  wire logic [7:0] kbd_byte_i,
  output logic            kbd_ready_o,
  // pointer receive
  input  wire logic       ptr_valid_i,
  input  wire logic [7:0] ptr_byte_i,
  output logic            ptr_ready_o,
  // keyboard transmit
  output logic            kbd_tx_valid_o,
  output logic [7:0]      kbd_tx_byte_o,
  // state view
  output logic [7:0]      command_byte_o
);

  typedef struct packed {
    logic            ldn;
    logic [7:0]      idx;
    logic [1:0][7:0] act;
    logic [1:0][7:0] irqs;
    logic [1:0][7:0] irqt;
    logic [1:0][7:0] dma;
    logic [7:0]      rng;
    logic [7:0]      bah;
    logic [7:0]      bal;
    logic [7:0]      cbh;
    logic [7:0]      cbl;
    logic [7:0]      cfgd;
    logic [7:0]      cmdb;
    logic [7:0]      ibuf;
    logic            ibf;
    logic            cmdf;
    logic [7:0]      obuf;
    logic            obf;
    logic            ob_ptr;
    logic            cb_pend;
    logic            brk;
    logic            turn;
    logic [7:0]      rdata;
    logic            kbd_rdy;
    logic            ptr_rdy;
    logic            tx_vld;
    logic [7:0]      tx_byte;
    logic            irq_kbd;
    logic            irq_ptr;
  } kbh_dev_state_t;

  kbh_dev_state_t s;
  kbh_dev_state_t next_s;

  // read value of the selected configuration register
  function automatic logic [7:0] cfg_read(input kbh_dev_state_t st);
    logic k;
    k = (st.ldn == 1'b0);
    case (st.idx)
      kbh_pkg::IDX_LDN:      cfg_read = {7'h00, st.ldn};
      kbh_pkg::IDX_ACTIVATE: cfg_read = st.act[st.ldn];
      kbh_pkg::IDX_RANGE:    cfg_read = k ? st.rng : 8'h00;
      kbh_pkg::IDX_BASE_HI:  cfg_read = k ? st.bah : 8'h00;
      kbh_pkg::IDX_BASE_LO:  cfg_read = k ? st.bal : 8'h00;
      kbh_pkg::IDX_CBASE_HI: cfg_read = k ? st.cbh : 8'h00;
      kbh_pkg::IDX_CBASE_LO: cfg_read = k ? st.cbl : 8'h00;
      kbh_pkg::IDX_IRQ_SEL:  cfg_read = st.irqs[st.ldn];
      kbh_pkg::IDX_IRQ_TYPE: cfg_read = st.irqt[st.ldn];
      kbh_pkg::IDX_DMA_SEL,
      kbh_pkg::IDX_DMA_RPT:  cfg_read = st.dma[st.ldn];
      kbh_pkg::IDX_CFG_DATA: cfg_read = k ? st.cfgd : 8'h00;
      default:               cfg_read = 8'h00;
    endcase
  endfunction

  logic       wr_data;
  logic       wr_cmd;
  logic       kbd_en;
  logic       ptr_en;
  logic       kbd_take;
  logic       ptr_take;
  logic       fetch;
  logic [7:0] status;

  always_comb begin
    next_s   = s;
    wr_data  = bus.wr && (bus.addr == kbh_pkg::PORT_DATA);
    wr_cmd   = bus.wr && (bus.addr == kbh_pkg::PORT_STATUS);
    kbd_en   = s.act[0][0] && !s.cmdb[kbh_pkg::CB_KBD_OFF];
    ptr_en   = s.act[1][0] && !s.cmdb[kbh_pkg::CB_PTR_OFF];
    kbd_take = kbd_valid_i && s.kbd_rdy;
    ptr_take = ptr_valid_i && s.ptr_rdy;
    status   = 8'h00;
    status[kbh_pkg::ST_CMD_DATA] = s.cmdf;
    status[kbh_pkg::ST_IBF]      = s.ibf;
    status[kbh_pkg::ST_OBF]      = s.obf;
    // fetch stalls while a peripheral loads or a response has no room
    fetch = s.ibf && !wr_data && !wr_cmd && !kbd_take && !ptr_take &&
            !(s.cmdf && (s.ibuf == kbh_pkg::CMD_READ_CB) && s.obf);
    next_s.tx_vld = 1'b0;
    next_s.turn   = !s.turn;

    // configuration path
    if (bus.wr && (bus.addr == kbh_pkg::PORT_CFG_INDEX)) begin
      next_s.idx = bus.wdata;
    end
    if (bus.wr && (bus.addr == kbh_pkg::PORT_CFG_DATA)) begin
      case (s.idx)
        kbh_pkg::IDX_LDN:      next_s.ldn = bus.wdata[0];
        kbh_pkg::IDX_ACTIVATE: next_s.act[s.ldn] = bus.wdata;
        kbh_pkg::IDX_RANGE:    if (!s.ldn) next_s.rng = bus.wdata;
        kbh_pkg::IDX_BASE_HI:  if (!s.ldn) next_s.bah = bus.wdata;
        kbh_pkg::IDX_BASE_LO:  if (!s.ldn) next_s.bal = bus.wdata;
        kbh_pkg::IDX_CBASE_HI: if (!s.ldn) next_s.cbh = bus.wdata;
        kbh_pkg::IDX_CBASE_LO: if (!s.ldn) next_s.cbl = bus.wdata;
        kbh_pkg::IDX_IRQ_SEL:  next_s.irqs[s.ldn] = bus.wdata;
        kbh_pkg::IDX_IRQ_TYPE: next_s.irqt[s.ldn] = bus.wdata;
        kbh_pkg::IDX_DMA_SEL:  next_s.dma[s.ldn] = bus.wdata;
        kbh_pkg::IDX_CFG_DATA: if (!s.ldn) next_s.cfgd = bus.wdata;
        default:               next_s.ldn = s.ldn;
      endcase
    end

    // controller fetches the input buffer byte
    if (fetch) begin
      next_s.ibf = 1'b0;
      if (s.cmdf) begin
        case (s.ibuf)
          kbh_pkg::CMD_READ_CB: begin
            next_s.obuf   = s.cmdb;
            next_s.obf    = 1'b1;
            next_s.ob_ptr = 1'b0;
          end
          kbh_pkg::CMD_WRITE_CB: next_s.cb_pend = 1'b1;
          default:               next_s.cb_pend = 1'b0;
        endcase
      end else if (s.cb_pend) begin
        next_s.cmdb    = s.ibuf & kbh_pkg::CB_WRITE_MASK;
        next_s.cb_pend = 1'b0;
      end else begin
        next_s.tx_vld  = 1'b1;
        next_s.tx_byte = s.ibuf;
      end
    end

    // peripheral bytes into the output buffer
    if (kbd_take) begin
      if (s.cmdb[kbh_pkg::CB_CONVERT] && (kbd_byte_i == kbh_pkg::CODE_BREAK)) begin
        next_s.brk = 1'b1;
      end else begin
        next_s.obuf   = s.brk ? (kbd_byte_i | kbh_pkg::CODE_REL_MASK) : kbd_byte_i;
        next_s.brk    = 1'b0;
        next_s.obf    = 1'b1;
        next_s.ob_ptr = 1'b0;
      end
    end else if (ptr_take) begin
      next_s.obuf   = ptr_byte_i;
      next_s.obf    = 1'b1;
      next_s.ob_ptr = 1'b1;
    end

    // host port reads, answered one cycle later
    next_s.rdata = 8'h00;
    if (bus.rd) begin
      case (bus.addr)
        kbh_pkg::PORT_CFG_INDEX: next_s.rdata = s.idx;
        kbh_pkg::PORT_CFG_DATA:  next_s.rdata = cfg_read(s);
        kbh_pkg::PORT_DATA: begin
          next_s.rdata = s.obuf;
          if (!kbd_take && !ptr_take) begin
            next_s.obf = 1'b0;
          end
        end
        kbh_pkg::PORT_STATUS:    next_s.rdata = status;
        default:                 next_s.rdata = 8'h00;
      endcase
    end

    // host writes to the buffer ports; a new write wins over a fetch
    if (wr_data || wr_cmd) begin
      next_s.ibuf = bus.wdata;
      next_s.ibf  = 1'b1;
      next_s.cmdf = wr_cmd;
    end

    // one receive side offered per cycle, alternating when both are on
    next_s.kbd_rdy = !next_s.obf && kbd_en && (!s.turn || !ptr_en);
    next_s.ptr_rdy = !next_s.obf && ptr_en && (s.turn || !kbd_en);
    next_s.irq_kbd = next_s.obf && !next_s.ob_ptr && s.act[0][0];
    next_s.irq_ptr = next_s.obf && next_s.ob_ptr && s.act[1][0];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s         <= '0;
      s.act     <= {kbh_pkg::RST_ACT_PTR, kbh_pkg::RST_ACT_KBD};
      s.irqs    <= {kbh_pkg::RST_IRQS_PTR, kbh_pkg::RST_IRQS_KBD};
      s.irqt    <= {kbh_pkg::RST_IRQ_TYPE, kbh_pkg::RST_IRQ_TYPE};
      s.dma     <= {kbh_pkg::RST_DMA, kbh_pkg::RST_DMA};
      s.rng     <= kbh_pkg::RST_RANGE;
      s.bah     <= kbh_pkg::RST_BASE_HI;
      s.bal     <= kbh_pkg::RST_BASE_LO;
      s.cbh     <= kbh_pkg::RST_CBASE;
      s.cbl     <= kbh_pkg::RST_CBASE;
      s.cfgd    <= kbh_pkg::RST_CFG_DATA;
      s.cmdb    <= kbh_pkg::RST_CMD_BYTE;
    end else begin
      s <= next_s;
    end
  end

  assign bus.rdata                   = s.rdata;
  assign bus.keyboard_interrupt_line = s.irq_kbd;
  assign bus.pointer_interrupt_line  = s.irq_ptr;
  assign kbd_ready_o                 = s.kbd_rdy;
  assign ptr_ready_o                 = s.ptr_rdy;
  assign kbd_tx_valid_o              = s.tx_vld;
  assign kbd_tx_byte_o               = s.tx_byte;
  assign command_byte_o              = s.cmdb;

endmodule

// ===== hdl/kbh_host.sv
// host cpu side: runs config and handshaked port accesses for software
`timescale 1ns/1ns
module kbh_host (
  // clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // software register port
  input  wire logic [1:0] sw_addr_i,
  input  wire logic [7:0] sw_wdata_i,
  input  wire logic       sw_wr_i,
  input  wire logic       sw_rd_i,
  output logic [7:0]      sw_rdata_o,
  // host bus
  kbh_if.host             bus
);

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CFG   = 3'b001,
    ST_POLL  = 3'b010,
    ST_PWAIT = 3'b011,
    ST_ACC   = 3'b100,
    ST_CAP   = 3'b101
  } kbh_host_st_t;

  typedef struct packed {
    kbh_host_st_t    st;
    kbh_pkg::kbh_op_t op;
    logic [7:0]      operand;
    logic [7:0]      result;
    logic [1:0]      step;
    logic            irq_kbd;
    logic            irq_ptr;
    logic [8:0]      addr;
    logic [7:0]      wdata;
    logic            wr;
    logic            rd;
    logic [7:0]      sw_rdata;
  } kbh_host_state_t;

  kbh_host_state_t s;
  kbh_host_state_t next_s;
  logic            busy;
  logic            is_read;

  always_comb begin
    next_s   = s;
    next_s.wr = 1'b0;
    next_s.rd = 1'b0;
    busy     = (s.st != ST_IDLE);
    is_read  = (s.op == kbh_pkg::OP_RD_DATA) || (s.op == kbh_pkg::OP_RD_STATUS);
    next_s.irq_kbd = bus.keyboard_interrupt_line;
    next_s.irq_ptr = bus.pointer_interrupt_line;
    next_s.sw_rdata = 8'h00;
    if (sw_rd_i) begin
      case (sw_addr_i)
        kbh_pkg::HREG_CTRL:    next_s.sw_rdata = {5'h00, s.op};
        kbh_pkg::HREG_OPERAND: next_s.sw_rdata = s.operand;
        kbh_pkg::HREG_RESULT:  next_s.sw_rdata = s.result;
        kbh_pkg::HREG_STATUS:  next_s.sw_rdata = {5'h00, s.irq_ptr, s.irq_kbd, busy};
        default:               next_s.sw_rdata = 8'h00;
      endcase
    end
    if (sw_wr_i && !busy) begin
      if (sw_addr_i == kbh_pkg::HREG_OPERAND) begin
        next_s.operand = sw_wdata_i;
      end
      if (sw_addr_i == kbh_pkg::HREG_CTRL) begin
        next_s.op   = kbh_pkg::kbh_op_t'(sw_wdata_i[2:0]);
        next_s.step = 2'h0;
        case (kbh_pkg::kbh_op_t'(sw_wdata_i[2:0]))
          kbh_pkg::OP_ACTIVATE:  next_s.st = ST_CFG;
          kbh_pkg::OP_RD_STATUS: next_s.st = ST_ACC;
          kbh_pkg::OP_WR_CMD,
          kbh_pkg::OP_WR_DATA,
          kbh_pkg::OP_RD_DATA:   next_s.st = ST_POLL;
          default:               next_s.st = ST_IDLE;
        endcase
      end
    end
    case (s.st)
      ST_IDLE: begin
        next_s.st = next_s.st;
      end
      ST_CFG: begin
        next_s.wr   = 1'b1;
        next_s.addr = s.step[0] ? kbh_pkg::PORT_CFG_DATA : kbh_pkg::PORT_CFG_INDEX;
        case (s.step)
          2'h0:    next_s.wdata = kbh_pkg::IDX_LDN;
          2'h1:    next_s.wdata = s.operand[0] ? kbh_pkg::LDN_PTR : kbh_pkg::LDN_KBD;
          2'h2:    next_s.wdata = kbh_pkg::IDX_ACTIVATE;
          default: next_s.wdata = kbh_pkg::ACTIVATE_ON;
        endcase
        next_s.step = s.step + 2'h1;
        if (s.step == 2'h3) begin
          next_s.st = ST_IDLE;
        end
      end
      ST_POLL: begin
        next_s.rd   = 1'b1;
        next_s.addr = kbh_pkg::PORT_STATUS;
        next_s.st   = ST_PWAIT;
      end
      ST_PWAIT: begin
        if (s.rd) begin
          next_s.st = ST_PWAIT;
        end else if (is_read ? bus.rdata[kbh_pkg::ST_OBF]
                             : !bus.rdata[kbh_pkg::ST_IBF]) begin
          next_s.st = ST_ACC;
        end else begin
          next_s.st = ST_POLL;
        end
      end
      ST_ACC: begin
        next_s.addr  = (s.op == kbh_pkg::OP_WR_DATA || s.op == kbh_pkg::OP_RD_DATA) ?
                       kbh_pkg::PORT_DATA : kbh_pkg::PORT_STATUS;
        next_s.wdata = s.operand;
        next_s.wr    = !is_read;
        next_s.rd    = is_read;
        next_s.st    = is_read ? ST_CAP : ST_IDLE;
      end
      ST_CAP: begin
        if (!s.rd) begin
          next_s.result = bus.rdata;
          next_s.st     = ST_IDLE;
        end
      end
      default: next_s.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bus.addr   = s.addr;
  assign bus.wdata  = s.wdata;
  assign bus.wr     = s.wr;
  assign bus.rd     = s.rd;
  assign sw_rdata_o = s.sw_rdata;

endmodule

// ===== test/kbh_props.sv
// assertions on the host i/o link between host and controller
`timescale 1ns/1ns
module kbh_props (
  // clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // link
  input wire logic [8:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       keyboard_interrupt_line,
  input wire logic       pointer_interrupt_line
);
  default clocking dclk @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic seen_a2;
  logic rd_data;
  logic rd_stat;
  logic wr_rdcb;
  assign rd_data = rd && addr == kbh_pkg::PORT_DATA;
  assign rd_stat = rd && addr == kbh_pkg::PORT_STATUS;
  assign wr_rdcb = wr && addr == kbh_pkg::PORT_STATUS && wdata == kbh_pkg::CMD_READ_CB;
  // last port write address line two
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seen_a2 <= 1'b0;
    end else if (wr && (addr == kbh_pkg::PORT_DATA || addr == kbh_pkg::PORT_STATUS)) begin
      seen_a2 <= addr[2];
    end
  end
  chk_rdata_idle: assert property (!rd |=> rdata == 8'h00)
    else $error("read data outside its slot");
  chk_status_flags: assert property (rd_stat |=> rdata[7:4] == 4'h0 && !rdata[2])
    else $error("general purpose flags not zero");
  chk_cmd_flag: assert property (rd_stat |=> rdata[3] == $past(seen_a2))
    else $error("command flag does not follow last write");
  chk_read_clears: assert property (
    rd_data |=> !keyboard_interrupt_line && !pointer_interrupt_line)
    else $error("interrupt still high after data read");
  chk_irq_one: assert property (!(keyboard_interrupt_line && pointer_interrupt_line))
    else $error("both interrupt lines high");
  chk_kbd_holds: assert property ($fell(keyboard_interrupt_line) |-> $past(rd_data))
    else $error("keyboard interrupt dropped without read");
  chk_ptr_holds: assert property ($fell(pointer_interrupt_line) |-> $past(rd_data))
    else $error("pointer interrupt dropped without read");
  chk_cmd_resp: assert property (
    wr_rdcb && !keyboard_interrupt_line && !pointer_interrupt_line
    |-> ##[1:6] keyboard_interrupt_line)
    else $error("no response to command byte read");
  cov_cmd_resp: cover property (wr_rdcb);
  cov_ptr_irq: cover property ($rose(pointer_interrupt_line));
  cov_kbd_read: cover property (rd_data && keyboard_interrupt_line);
endmodule

// ===== test/tb.sv
// self-checking bench: host and controller joined over the link
`timescale 1ns/1ns
module tb;
  logic       clk_i;
  logic       rst_i;
  logic [1:0] sw_addr;
  logic [7:0] sw_wdata;
  logic       sw_wr;
  logic       sw_rd;
  logic [7:0] sw_rdata;
  logic       kbd_valid, ptr_valid, kbd_ready, ptr_ready, tx_valid;
  logic [7:0] kbd_byte, ptr_byte, tx_byte, cmd_byte, res;
  logic [7:0] tx_cnt = 8'h00;
  logic [7:0] tx_last;
  int         n_errors;
  int         total_checks;
  int         cycles;
  kbh_if link ();
  kbh_device kbh_device_i (.clk_i(clk_i), .rst_i(rst_i), .bus(link), .kbd_valid_i(kbd_valid),
    .kbd_byte_i(kbd_byte), .kbd_ready_o(kbd_ready), .ptr_valid_i(ptr_valid),
    .ptr_byte_i(ptr_byte), .ptr_ready_o(ptr_ready), .kbd_tx_valid_o(tx_valid),
    .kbd_tx_byte_o(tx_byte), .command_byte_o(cmd_byte));
  kbh_host kbh_host_i (.clk_i(clk_i), .rst_i(rst_i), .sw_addr_i(sw_addr), .sw_wdata_i(sw_wdata),
    .sw_wr_i(sw_wr), .sw_rd_i(sw_rd), .sw_rdata_o(sw_rdata), .bus(link));
  kbh_props kbh_props_i (.clk_i(clk_i), .rst_i(rst_i), .addr(link.addr), .wdata(link.wdata),
    .wr(link.wr), .rd(link.rd), .rdata(link.rdata),
    .keyboard_interrupt_line(link.keyboard_interrupt_line),
    .pointer_interrupt_line(link.pointer_interrupt_line));
  always #50 clk_i = ~clk_i;
  // bytes forwarded to the keyboard
  always @(posedge clk_i) begin
    if (tx_valid === 1'b1) begin
      tx_cnt <= tx_cnt + 8'h01;
      tx_last <= tx_byte;
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic sw_write(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk_i);
    sw_wr <= 1'b0;
  endtask
  task automatic sw_read(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_i);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk_i);
    sw_rd <= 1'b0;
    @(negedge clk_i);
    d = sw_rdata;
  endtask
  // start one host operation and wait until it is no longer busy
  task automatic run_op(input kbh_pkg::kbh_op_t op, input logic [7:0] operand);
    logic [7:0] st;
    int i;
    sw_write(kbh_pkg::HREG_OPERAND, operand);
    sw_write(kbh_pkg::HREG_CTRL, {5'h00, op});
    i = 0;
    do begin
      sw_read(kbh_pkg::HREG_STATUS, st);
      i++;
    end while (st[0] !== 1'b0 && i < 300);
    check(st & 8'h01, 8'h00);
    // a last write reaches the input buffer one cycle after idle and is fetched one later
    repeat (2) @(negedge clk_i);
  endtask
  task automatic set_cb(input logic [7:0] v);
    run_op(kbh_pkg::OP_WR_CMD, kbh_pkg::CMD_WRITE_CB);
    run_op(kbh_pkg::OP_WR_DATA, v);
  endtask
  task automatic host_read(output logic [7:0] d);
    run_op(kbh_pkg::OP_RD_DATA, 8'h00);
    sw_read(kbh_pkg::HREG_RESULT, d);
  endtask
  // offer a byte from keyboard (sel 0) or pointer (sel 1)
  task automatic offer(input logic sel, input logic [7:0] b, input logic take);
    int i;
    @(posedge clk_i);
    kbd_valid <= !sel;
    ptr_valid <= sel;
    kbd_byte <= b;
    ptr_byte <= b;
    i = 0;
    do begin
      @(negedge clk_i);
      i++;
      if (!take) begin
        check({7'h00, sel ? ptr_ready : kbd_ready}, 8'h00);
      end
    end while (take && (sel ? ptr_ready : kbd_ready) !== 1'b1 && i < 50);
    if (take) begin
      check({7'h00, sel ? ptr_ready : kbd_ready}, 8'h01);
    end
    @(posedge clk_i);
    kbd_valid <= 1'b0;
    ptr_valid <= 1'b0;
  endtask
  task automatic t_cmd_byte();
    logic [7:0] vals [4] = '{8'hCB, 8'h04, 8'h40, 8'h00};
    logic [7:0] n;
    n = tx_cnt;
    check(cmd_byte, kbh_pkg::RST_CMD_BYTE);
    foreach (vals[k]) begin
      set_cb(vals[k]);
      check(cmd_byte, vals[k] & kbh_pkg::CB_WRITE_MASK);
      run_op(kbh_pkg::OP_WR_CMD, kbh_pkg::CMD_READ_CB);
      host_read(res);
      check(res, vals[k] & kbh_pkg::CB_WRITE_MASK);
    end
    check(tx_cnt, n);
    run_op(kbh_pkg::OP_RD_STATUS, 8'h00);
    sw_read(kbh_pkg::HREG_RESULT, res);
    check(res, 8'h08);
    $display("test cmd_byte done");
  endtask
  task automatic t_data_fwd();
    logic [7:0] n;
    n = tx_cnt;
    run_op(kbh_pkg::OP_WR_DATA, 8'hA5);
    repeat (4) @(posedge clk_i);
    check(tx_cnt, n + 8'h01);
    check(tx_last, 8'hA5);
    run_op(kbh_pkg::OP_RD_STATUS, 8'h00);
    sw_read(kbh_pkg::HREG_RESULT, res);
    check(res, 8'h00);
    $display("test data_fwd done");
  endtask
  task automatic t_receive();
    offer(1'b0, 8'h3C, 1'b1);
    sw_read(kbh_pkg::HREG_STATUS, res);
    check(res & 8'h06, 8'h02);
    host_read(res);
    check(res, 8'h3C);
    set_cb(8'h40);
    offer(1'b0, kbh_pkg::CODE_BREAK, 1'b1);
    offer(1'b0, 8'h12, 1'b1);
    host_read(res);
    check(res, 8'h92);
    $display("test receive done");
  endtask
  task automatic t_pointer();
    set_cb(8'h00);
    offer(1'b1, 8'h5A, 1'b0);
    run_op(kbh_pkg::OP_ACTIVATE, kbh_pkg::LDN_PTR);
    offer(1'b1, 8'h5A, 1'b1);
    sw_read(kbh_pkg::HREG_STATUS, res);
    check(res & 8'h06, 8'h04);
    host_read(res);
    check(res, 8'h5A);
    set_cb(8'h20);
    offer(1'b1, 8'h11, 1'b0);
    set_cb(8'h10);
    offer(1'b0, 8'h22, 1'b0);
    $display("test pointer done");
  endtask
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    sw_addr = 2'h0;
    sw_wdata = 8'h00;
    sw_wr = 1'b0;
    sw_rd = 1'b0;
    kbd_valid = 1'b0;
    ptr_valid = 1'b0;
    kbd_byte = 8'h00;
    ptr_byte = 8'h00;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_cmd_byte();
    t_data_fwd();
    t_receive();
    t_pointer();
    complete_run();
  end
endmodule
